// *** logic/ccr_regs.svh ***
/*
 * Register offsets, field positions and pulse widths of the correlator control bank.
 * Assumes a 16-bit control computer bus with word offsets 0x0..0x4.
 */
// Behaviour
// - Register 0 field picks which of eight event lines drives sampler 0 sync.
// - Register 0 field picks which event line drives sampler 0 blanking.
// - Register 0 field picks which event line drives correlator 0 blanking.
// - Register 0 field picks which event line drives correlator 0 integrate.
// - Register 0 field picks which event line drives correlator 0 run.
// - Register 1 is write-only, same routing for correlator 1.
// - Test bit puts the matching correlator into internal test mode.
// - Double bit puts the matching correlator into double rate mode.
// - Reset bit pulses accumulator reset, at least one correlator clock long.
// - Correlator 1 mode bits pick X and Y source: generator or cascade.
// - Both correlator 1 mode bits set concatenates the two chips.
// - Register 4 field picks transfer trigger line; next bit reserved.
// - Window offset gives the three top auxiliary bus address bits.
// - Half select routes low or high event bus byte as event lines.
// - Config target select steers programming bits to device 2 or 4.
// - PROM reset bit resets the serial PROM before reading.
// - PROM advance bit steps the PROM; read returns PROM data.
// - Config clock bit pulses selected device clock; rising edge takes data.
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define CCR_OFS_ROUTE0     4'h0
`define CCR_OFS_ROUTE1     4'h1
`define CCR_OFS_MODE0      4'h2
`define CCR_OFS_MODE1      4'h3
`define CCR_OFS_XFER       4'h4

// ----------------------------------------------------------------
// Routing register fields (low bit of each 3-bit field)
// ----------------------------------------------------------------
`define CCR_RT_SMP_SYNC    0
`define CCR_RT_SMP_BLANK   3
`define CCR_RT_COR_BLANK   6
`define CCR_RT_COR_INTEG   9
`define CCR_RT_COR_RUN     12

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define CCR_MD_INMODE      0
`define CCR_MD_TEST        2
`define CCR_MD_DOUBLE      3
`define CCR_MD_RESET       4

// ----------------------------------------------------------------
// Register 4 fields
// ----------------------------------------------------------------
`define CCR_X_TRIG         0
`define CCR_X_TRIG_RSVD    3
`define CCR_X_WINDOW       4
`define CCR_X_SN_CFG       7
`define CCR_X_HALF         8
`define CCR_X_TARGET       9
`define CCR_X_PROM_RST     10
`define CCR_X_PROM_ADV     11
`define CCR_X_CFG_PROG     12
`define CCR_X_CFG_CLK      13
`define CCR_X_CFG_RST      14
`define CCR_X_MASTER       15

// ----------------------------------------------------------------
// Pulse widths in system clocks
// ----------------------------------------------------------------
`define CCR_PULSE_CYC      4'h4

`endif

// *** logic/ccr_pkg.sv ***
/*
 * Types shared by the correlator control bank.
 * Assumes nothing beyond the register header.
 */
package ccr_pkg;

    // Event selections of one correlator
    typedef struct packed {
        logic [2:0] run_sel;
        logic [2:0] integ_sel;
        logic [2:0] blank_sel;
        logic [2:0] smp_blank_sel;
        logic [2:0] smp_sync_sel;
    } ccr_route_s;

    // Mode outputs of one correlator
    typedef struct packed {
        logic [1:0] in_mode;
        logic       test;
        logic       dbl;
        logic       acc_reset;
    } ccr_mode_s;

endpackage

// *** logic/ccr_pulse.sv ***
/*
 * Stretches a one-cycle trigger into a fixed-width high pulse.
 * Assumes the width covers the slowest clock of the pulse target.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.svh"

module ccr_pulse #(
    parameter logic [3:0] WIDTH = `CCR_PULSE_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Trigger and pulse
    input  wire logic trig,
    output var  logic pulse
);

    logic [3:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
        end else if (trig) begin
            cnt_reg <= WIDTH;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    assign pulse = (cnt_reg != 4'h0);

endmodule

`default_nettype wire

// *** logic/ccr_route.sv ***
/*
 * Selects five event lines for one correlator from eight.
 * Assumes event lines already chosen by the bus half select.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_route (
    // Selection and lines
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire ccr_pkg::ccr_route_s sel,
    input  wire logic [7:0]        events,
    // Routed signals: run, integ, blank, smp_blank, smp_sync
    output var  logic [4:0]        routed
);

    logic [14:0] sel_flat;

    assign sel_flat = sel;

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_sel
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    routed[i] <= 1'b0;
                end else begin
                    routed[i] <= events[sel_flat[3*i +: 3]];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// *** logic/ccr_ctrl.sv ***
/*
 * Correlator control register bank: event routing, chip modes, transfer
 * trigger, auxiliary window, serial PROM and configuration programming.
 * Assumes a synchronous 16-bit control computer bus with one-cycle write
 * and read strobes and a word address.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.svh"

module ccr_ctrl #(
    parameter logic [3:0] PULSE_CYC = `CCR_PULSE_CYC
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,

    // Control computer bus
    input  wire logic [3:0]  BUS_ADDR,
    input  wire logic [15:0] BUS_WDATA,
    input  wire logic        BUS_WR,
    input  wire logic        BUS_RD,
    output var  logic [15:0] BUS_RDATA,

    // Timed event bus
    input  wire logic [15:0] EVENT_BUS,

    // Correlator 0
    output var  logic [4:0]  COR0_ROUTED,
    output var  logic [1:0]  COR0_IN_MODE,
    output var  logic        COR0_TEST,
    output var  logic        COR0_DOUBLE,
    output var  logic        COR0_ACC_RESET,

    // Correlator 1
    output var  logic [4:0]  COR1_ROUTED,
    output var  logic        COR1_X_CASCADE,
    output var  logic        COR1_Y_CASCADE,
    output var  logic        COR1_CONCAT,
    output var  logic        COR1_TEST,
    output var  logic        COR1_DOUBLE,
    output var  logic        COR1_ACC_RESET,

    // Transfer controller and auxiliary bus
    output var  logic        XFER_TRIGGER,
    output var  logic [2:0]  AUX_ADDR_HIGH,

    // Serial number PROM
    input  wire logic        PROM_DATA,
    output var  logic        PROM_ENABLE,
    output var  logic        PROM_RESET,
    output var  logic        PROM_ADVANCE,

    // Configuration devices 2 and 4
    input  wire logic        CFG_DONE,
    output var  logic        CFG_DATA,
    output var  logic [1:0]  CFG_CLK,
    output var  logic [1:0]  CFG_PROG,
    output var  logic [1:0]  CFG_RESET,

    // Clock sync master
    output var  logic        CLK_SYNC_MASTER
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    ccr_pkg::ccr_route_s route0_reg;
    ccr_pkg::ccr_route_s route1_reg;
    logic [3:0]          mode0_reg;
    logic [3:0]          mode1_reg;
    logic [15:0]         xfer_reg;

    logic [15:0]         rdata_next;
    logic [7:0]          events;

    // Write strobes
    logic                wr_route0;
    logic                wr_route1;
    logic                wr_mode0;
    logic                wr_mode1;
    logic                wr_xfer;

    // Action triggers and pulses
    logic                trig_acc0;
    logic                trig_acc1;
    logic                trig_prst;
    logic                trig_padv;
    logic                trig_cclk;
    logic                trig_cprog;
    logic                trig_crst;
    logic                clk_pulse;
    logic                prog_pulse;
    logic                rst_pulse;

    assign wr_route0 = BUS_WR && (BUS_ADDR == `CCR_OFS_ROUTE0);
    assign wr_route1 = BUS_WR && (BUS_ADDR == `CCR_OFS_ROUTE1);
    assign wr_mode0  = BUS_WR && (BUS_ADDR == `CCR_OFS_MODE0);
    assign wr_mode1  = BUS_WR && (BUS_ADDR == `CCR_OFS_MODE1);
    assign wr_xfer   = BUS_WR && (BUS_ADDR == `CCR_OFS_XFER);

    // Accumulator resets
    assign trig_acc0  = wr_mode0 && BUS_WDATA[`CCR_MD_RESET];
    assign trig_acc1  = wr_mode1 && BUS_WDATA[`CCR_MD_RESET];

    // Register 4 action bits, one pulse per write
    assign trig_prst  = wr_xfer && BUS_WDATA[`CCR_X_PROM_RST];
    assign trig_padv  = wr_xfer && BUS_WDATA[`CCR_X_PROM_ADV];
    assign trig_cclk  = wr_xfer && BUS_WDATA[`CCR_X_CFG_CLK];
    assign trig_cprog = wr_xfer && BUS_WDATA[`CCR_X_CFG_PROG];
    assign trig_crst  = wr_xfer && BUS_WDATA[`CCR_X_CFG_RST];

    // ----------------------------------------------------------------
    // Routing registers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            route0_reg <= '0;
        end else if (wr_route0) begin
            route0_reg <= BUS_WDATA[14:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            route1_reg <= '0;
        end else if (wr_route1) begin
            route1_reg <= BUS_WDATA[14:0];
        end
    end

    // ----------------------------------------------------------------
    // Mode registers: input mode, test, double
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode0_reg <= 4'h0;
        end else if (wr_mode0) begin
            mode0_reg <= BUS_WDATA[`CCR_MD_DOUBLE:`CCR_MD_INMODE];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode1_reg <= 4'h0;
        end else if (wr_mode1) begin
            mode1_reg <= BUS_WDATA[`CCR_MD_DOUBLE:`CCR_MD_INMODE];
        end
    end

    // ----------------------------------------------------------------
    // Register 4 stored fields; action bits never stored
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            xfer_reg <= 16'h0000;
        end else if (wr_xfer) begin
            xfer_reg <= BUS_WDATA & 16'h83ff;
        end
    end

    // ----------------------------------------------------------------
    // Event lines and routing
    // ----------------------------------------------------------------
    assign events = xfer_reg[`CCR_X_HALF] ? EVENT_BUS[15:8] : EVENT_BUS[7:0];

    ccr_route u_route0 (
        .clk    (SYS_CLK),
        .rst_n  (RST_N),
        .sel    (route0_reg),
        .events (events),
        .routed (COR0_ROUTED)
    );

    ccr_route u_route1 (
        .clk    (SYS_CLK),
        .rst_n  (RST_N),
        .sel    (route1_reg),
        .events (events),
        .routed (COR1_ROUTED)
    );

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            XFER_TRIGGER <= 1'b0;
        end else begin
            XFER_TRIGGER <= events[xfer_reg[`CCR_X_TRIG +: 3]];
        end
    end

    // ----------------------------------------------------------------
    // Mode outputs
    // ----------------------------------------------------------------
    assign COR0_IN_MODE   = mode0_reg[1:0];
    assign COR0_TEST      = mode0_reg[`CCR_MD_TEST];
    assign COR0_DOUBLE    = mode0_reg[`CCR_MD_DOUBLE];
    assign COR1_X_CASCADE = mode1_reg[0];
    assign COR1_Y_CASCADE = mode1_reg[1];
    assign COR1_CONCAT    = mode1_reg[0] && mode1_reg[1];
    assign COR1_TEST      = mode1_reg[`CCR_MD_TEST];
    assign COR1_DOUBLE    = mode1_reg[`CCR_MD_DOUBLE];

    // ----------------------------------------------------------------
    // Action pulses
    // ----------------------------------------------------------------
    ccr_pulse #(.WIDTH(PULSE_CYC)) u_acc0 (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .trig  (trig_acc0),
        .pulse (COR0_ACC_RESET)
    );

    ccr_pulse #(.WIDTH(PULSE_CYC)) u_acc1 (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .trig  (trig_acc1),
        .pulse (COR1_ACC_RESET)
    );

    ccr_pulse #(.WIDTH(PULSE_CYC)) u_prst (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .trig  (trig_prst),
        .pulse (PROM_RESET)
    );

    ccr_pulse #(.WIDTH(PULSE_CYC)) u_padv (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .trig  (trig_padv),
        .pulse (PROM_ADVANCE)
    );

    ccr_pulse #(.WIDTH(PULSE_CYC)) u_cclk (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .trig  (trig_cclk),
        .pulse (clk_pulse)
    );

    ccr_pulse #(.WIDTH(PULSE_CYC)) u_cprog (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .trig  (trig_cprog),
        .pulse (prog_pulse)
    );

    ccr_pulse #(.WIDTH(PULSE_CYC)) u_crst (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .trig  (trig_crst),
        .pulse (rst_pulse)
    );

    // ----------------------------------------------------------------
    // Auxiliary window, PROM and configuration steering
    // ----------------------------------------------------------------
    assign AUX_ADDR_HIGH   = xfer_reg[`CCR_X_WINDOW +: 3];
    assign PROM_ENABLE     = xfer_reg[`CCR_X_SN_CFG];
    assign CFG_DATA        = xfer_reg[`CCR_X_SN_CFG];
    assign CLK_SYNC_MASTER = xfer_reg[`CCR_X_MASTER];

    // Index 0 is device 2, index 1 is device 4
    always_comb begin
        CFG_CLK   = 2'b00;
        CFG_PROG  = 2'b00;
        CFG_RESET = 2'b00;
        if (xfer_reg[`CCR_X_TARGET]) begin
            CFG_CLK[1]   = clk_pulse;
            CFG_PROG[1]  = prog_pulse;
            CFG_RESET[1] = rst_pulse;
        end else begin
            CFG_CLK[0]   = clk_pulse;
            CFG_PROG[0]  = prog_pulse;
            CFG_RESET[0] = rst_pulse;
        end
    end

    // ----------------------------------------------------------------
    // Read path: only register 4 reads back
    // ----------------------------------------------------------------
    always_comb begin
        rdata_next = 16'h0000;
        if (BUS_ADDR == `CCR_OFS_XFER) begin
            rdata_next                  = xfer_reg;
            rdata_next[`CCR_X_PROM_ADV] = PROM_DATA;
            rdata_next[`CCR_X_CFG_PROG] = CFG_DONE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_RDATA <= 16'h0000;
        end else if (BUS_RD) begin
            BUS_RDATA <= rdata_next;
        end
    end

endmodule

`default_nettype wire

// *** tb/ccr_far_model.sv ***
/*
 * Stand-in for the serial number PROM and the configuration devices.
 * Assumes the control bank's pulses and levels on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_far_model #(
    parameter logic [7:0] SERIAL = 8'h5a // Arbitrary serial value
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bank outputs
    input  wire logic       prom_en,
    input  wire logic       prom_rst,
    input  wire logic       prom_adv,
    input  wire logic [1:0] cfg_prog,
    input  wire logic [1:0] cfg_clk,
    // Answers
    output var  logic       prom_data,
    output var  logic       cfg_done
);
    logic [2:0] ptr_reg;
    logic [2:0] clks_reg;
    logic       rst_d_reg;
    logic       adv_d_reg;
    logic       tgl_reg;
    logic [1:0] clk_d_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ptr_reg, rst_d_reg, adv_d_reg, tgl_reg} <= '0;
        end else begin
            rst_d_reg <= prom_rst;
            adv_d_reg <= prom_adv;
            tgl_reg   <= ~tgl_reg;
            if (prom_rst && !rst_d_reg) ptr_reg <= '0;
            else if (prom_adv && !adv_d_reg) ptr_reg <= ptr_reg + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_d_reg <= '0;
            clks_reg  <= '0;
            cfg_done  <= 1'b1;
        end else begin
            clk_d_reg <= cfg_clk;
            if (|cfg_prog) begin
                cfg_done <= 1'b0;
                clks_reg <= '0;
            end else if (|(cfg_clk & ~clk_d_reg)) begin
                clks_reg <= clks_reg + 3'h1;
                if (clks_reg == 3'h3) cfg_done <= 1'b1;
            end
        end
    end

    // Released line toggles rather than holding the last bit
    assign prom_data = prom_en ? SERIAL[ptr_reg] : tgl_reg;
endmodule

`default_nettype wire

// *** tb/ccr_ctrl_checker.sv ***
/*
 * Concurrent checks on the correlator control bank ports.
 * Assumes binding to the bank top module, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_ctrl_checker #(
    parameter logic [3:0] PULSE_CYC = 4'h4
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // Bus and events
    input  wire logic [3:0]  BUS_ADDR,
    input  wire logic [15:0] BUS_WDATA,
    input  wire logic        BUS_WR,
    input  wire logic [15:0] EVENT_BUS,
    // Watched outputs
    input  wire logic        COR0_TEST,
    input  wire logic        COR0_DOUBLE,
    input  wire logic        COR0_ACC_RESET,
    input  wire logic        COR1_ACC_RESET,
    input  wire logic        COR1_X_CASCADE,
    input  wire logic        COR1_Y_CASCADE,
    input  wire logic        COR1_CONCAT,
    input  wire logic        XFER_TRIGGER,
    input  wire logic [2:0]  AUX_ADDR_HIGH,
    input  wire logic        PROM_ADVANCE,
    input  wire logic [1:0]  CFG_CLK
);
    logic       w4;
    logic [3:0] idx_reg;
    logic [3:0] run_reg;

    assign w4 = BUS_WR && (BUS_ADDR == 4'h4);

    // ----------------------------------------------------------------
    // Shadow of the trigger select and pulse length
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) idx_reg <= '0;
        else if (w4) idx_reg <= {BUS_WDATA[8], BUS_WDATA[2:0]};
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) run_reg <= '0;
        else run_reg <= COR1_ACC_RESET ? run_reg + 4'h1 : 4'h0;
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    a_test_level: assert property (BUS_WR && BUS_ADDR == 4'h2 |=> COR0_TEST == $past(BUS_WDATA[2]))
        else $error("test level does not follow write");
    a_double_level: assert property (BUS_WR && BUS_ADDR == 4'h2 |=> COR0_DOUBLE == $past(BUS_WDATA[3]))
        else $error("double level does not follow write");
    a_acc_pulse: assert property (BUS_WR && BUS_ADDR == 4'h2 && BUS_WDATA[4] |=> COR0_ACC_RESET [*4])
        else $error("accumulator reset pulse too short");
    a_acc_width: assert property ($fell(COR1_ACC_RESET) |-> run_reg >= PULSE_CYC)
        else $error("accumulator reset high too briefly");
    a_cascade_map: assert property (BUS_WR && BUS_ADDR == 4'h3 |=>
        {COR1_Y_CASCADE, COR1_X_CASCADE} == $past(BUS_WDATA[1:0]))
        else $error("cascade selects wrong");
    a_concat_both: assert property (BUS_WR && BUS_ADDR == 4'h3 |=> COR1_CONCAT == &$past(BUS_WDATA[1:0]))
        else $error("concatenation wrong");
    a_window_bits: assert property (w4 |=> AUX_ADDR_HIGH == $past(BUS_WDATA[6:4]))
        else $error("window bits wrong");
    a_cfg_clk_target: assert property (w4 && BUS_WDATA[13] |=>
        CFG_CLK == ($past(BUS_WDATA[9]) ? 2'b10 : 2'b01))
        else $error("configuration clock on wrong device");
    a_adv_cause: assert property ($rose(PROM_ADVANCE) |-> $past(w4 && BUS_WDATA[11]))
        else $error("advance pulse without write");
    a_xfer_route: assert property ($past(RST_N, 3) && !$past(w4) && !$past(w4, 2) && !$past(w4, 3)
        |-> XFER_TRIGGER == $past(EVENT_BUS[idx_reg]))
        else $error("transfer trigger line wrong");
endmodule

`default_nettype wire

// *** tb/ccr_ctrl_tb.sv ***
/*
 * Self-checking bench of the correlator control bank.
 * Assumes the far model for PROM and configuration answers.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_ctrl_tb;
    localparam logic [3:0] PULSE = 4'h4;
    localparam logic [7:0] SN    = 8'h5a;
    logic        SYS_CLK   = 1'b0;
    logic        RST_N     = 1'b0;
    logic [3:0]  BUS_ADDR  = '0;
    logic [15:0] BUS_WDATA = '0;
    logic        BUS_WR    = 1'b0;
    logic        BUS_RD    = 1'b0;
    logic [15:0] EVENT_BUS = '0;
    logic [15:0] BUS_RDATA, rv, r0, r1, r4;
    logic [4:0]  COR0_ROUTED, COR1_ROUTED;
    logic [1:0]  COR0_IN_MODE, CFG_CLK, CFG_PROG, CFG_RESET;
    logic        COR0_TEST, COR0_DOUBLE, COR0_ACC_RESET, COR1_X_CASCADE, COR1_Y_CASCADE, COR1_CONCAT;
    logic        COR1_TEST, COR1_DOUBLE, COR1_ACC_RESET, XFER_TRIGGER, PROM_DATA, PROM_ENABLE;
    logic        PROM_RESET, PROM_ADVANCE, CFG_DONE, CFG_DATA, CLK_SYNC_MASTER;
    logic [2:0]  AUX_ADDR_HIGH;
    logic [7:0]  ev8;
    logic [3:0]  mv;
    int          err_total = 0;
    int          tests_run = 0;

    always #10 SYS_CLK = ~SYS_CLK;

    ccr_ctrl #(.PULSE_CYC(PULSE)) i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .BUS_ADDR(BUS_ADDR),
        .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .EVENT_BUS(EVENT_BUS),
        .COR0_ROUTED(COR0_ROUTED), .COR0_IN_MODE(COR0_IN_MODE), .COR0_TEST(COR0_TEST), .COR0_DOUBLE(COR0_DOUBLE),
        .COR0_ACC_RESET(COR0_ACC_RESET), .COR1_ROUTED(COR1_ROUTED), .COR1_X_CASCADE(COR1_X_CASCADE),
        .COR1_Y_CASCADE(COR1_Y_CASCADE), .COR1_CONCAT(COR1_CONCAT), .COR1_TEST(COR1_TEST),
        .COR1_DOUBLE(COR1_DOUBLE), .COR1_ACC_RESET(COR1_ACC_RESET), .XFER_TRIGGER(XFER_TRIGGER),
        .AUX_ADDR_HIGH(AUX_ADDR_HIGH), .PROM_DATA(PROM_DATA), .PROM_ENABLE(PROM_ENABLE), .PROM_RESET(PROM_RESET),
        .PROM_ADVANCE(PROM_ADVANCE), .CFG_DONE(CFG_DONE), .CFG_DATA(CFG_DATA), .CFG_CLK(CFG_CLK),
        .CFG_PROG(CFG_PROG), .CFG_RESET(CFG_RESET), .CLK_SYNC_MASTER(CLK_SYNC_MASTER));

    ccr_far_model #(.SERIAL(SN)) i_far (.clk(SYS_CLK), .rst_n(RST_N), .prom_en(PROM_ENABLE),
        .prom_rst(PROM_RESET), .prom_adv(PROM_ADVANCE), .cfg_prog(CFG_PROG), .cfg_clk(CFG_CLK),
        .prom_data(PROM_DATA), .cfg_done(CFG_DONE));

    function automatic logic [4:0] route(input logic [15:0] r, input logic [7:0] e);
        for (int k = 0; k < 5; k++) route[k] = e[r[3*k +: 3]];
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge SYS_CLK) #2;
        BUS_WR    = 1'b1;
        BUS_ADDR  = a;
        BUS_WDATA = d;
        @(posedge SYS_CLK) #2;
        BUS_WR = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge SYS_CLK) #2;
        BUS_RD   = 1'b1;
        BUS_ADDR = a;
        @(posedge SYS_CLK) #2;
        BUS_RD = 1'b0;
        d = BUS_RDATA;
    endtask

    // Counts high cycles of every pulse output over eight cycles
    task automatic pulses(input logic [9:0] mask);
        logic [9:0] v;
        int         n [10] = '{default: 0};
        for (int c = 0; c < 8; c++) begin
            v = {PROM_ADVANCE, PROM_RESET, CFG_RESET, CFG_PROG, CFG_CLK, COR1_ACC_RESET, COR0_ACC_RESET};
            for (int b = 0; b < 10; b++) n[b] += int'(v[b] === 1'b1);
            @(posedge SYS_CLK) #2;
        end
        for (int b = 0; b < 10; b++) check("pulse width", mask[b] ? 16'(PULSE) : 16'h0, 16'(n[b]));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hf02f));
        repeat (10) @(posedge SYS_CLK);
        #2;
        RST_N = 1'b1;
        wr(4'h7, 16'hffff);
        rd(4'h7, rv);
        check("unmapped", 16'h0, rv);
        // Random routing, first pass forces the upper half
        for (int i = 0; i < 20; i++) begin
            r0 = 16'($urandom()) & 16'h7fff;
            r1 = 16'($urandom()) & 16'h7fff;
            r4 = (16'($urandom()) & 16'hefff) | (i == 0 ? 16'h0100 : 16'h0);
            wr(4'h0, r0);
            wr(4'h1, r1);
            wr(4'h4, r4);
            EVENT_BUS = 16'($urandom());
            repeat (4) @(posedge SYS_CLK);
            #2;
            ev8 = r4[8] ? EVENT_BUS[15:8] : EVENT_BUS[7:0];
            check("routed 0", 16'(route(r0, ev8)), 16'(COR0_ROUTED));
            check("routed 1", 16'(route(r1, ev8)), 16'(COR1_ROUTED));
            check("transfer line", 16'(ev8[r4[2:0]]), 16'(XFER_TRIGGER));
            check("window", 16'(r4[6:4]), 16'(AUX_ADDR_HIGH));
            check("master and enable", {14'h0, r4[15], r4[7]}, {14'h0, CLK_SYNC_MASTER, PROM_ENABLE});
            rd(4'h4, rv);
            check("reg 4", (r4 & 16'h83ff) | 16'h1000, rv & 16'hf7ff);
            rd(4'(i % 4), rv);
            check("write only", 16'h0, rv);
        end
        for (int m = 0; m < 16; m++) begin
            mv = 4'(m);
            wr(4'h2, {12'h0, mv & 4'hc});
            wr(4'h3, {12'h0, mv});
            @(posedge SYS_CLK) #2;
            check("corr 0 mode", {12'h0, mv & 4'hc}, 16'({COR0_DOUBLE, COR0_TEST, COR0_IN_MODE}));
            check("corr 1 mode", {11'h0, mv[1] & mv[0], mv},
                16'({COR1_CONCAT, COR1_DOUBLE, COR1_TEST, COR1_Y_CASCADE, COR1_X_CASCADE}));
        end
        wr(4'h2, 16'h0010);
        pulses(10'h001);
        wr(4'h3, 16'h0010);
        pulses(10'h002);
        for (int t = 0; t < 2; t++) begin
            wr(4'h4, 16'h4000 | 16'(t << 9));
            pulses(t ? 10'h080 : 10'h040);
            wr(4'h4, 16'h1000 | 16'(t << 9));
            pulses(t ? 10'h020 : 10'h010);
            rd(4'h4, rv);
            check("config done low", 16'h0, 16'(rv[12]));
            for (int k = 0; k < 4; k++) begin
                wr(4'h4, 16'(t << 9) | {8'h0, k[0], 7'h0});
                @(posedge SYS_CLK) #2;
                check("config data", 16'(k[0]), 16'(CFG_DATA));
                wr(4'h4, 16'h2000 | 16'(t << 9) | {8'h0, k[0], 7'h0});
                pulses(t ? 10'h008 : 10'h004);
            end
            rd(4'h4, rv);
            check("config done high", 16'h1, 16'(rv[12]));
        end
        // Serial read with the window left alone throughout
        wr(4'h4, 16'h0480);
        pulses(10'h100);
        for (int i = 0; i < 8; i++) begin
            rd(4'h4, rv);
            check("serial bit", 16'(SN[i]), 16'(rv[11]));
            wr(4'h4, 16'h0880);
            pulses(10'h200);
        end
        tally_and_finish();
    end
endmodule

bind ccr_ctrl ccr_ctrl_checker #(.PULSE_CYC(PULSE_CYC)) i_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .EVENT_BUS(EVENT_BUS), .COR0_TEST(COR0_TEST),
    .COR0_DOUBLE(COR0_DOUBLE), .COR0_ACC_RESET(COR0_ACC_RESET), .COR1_ACC_RESET(COR1_ACC_RESET),
    .COR1_X_CASCADE(COR1_X_CASCADE), .COR1_Y_CASCADE(COR1_Y_CASCADE), .COR1_CONCAT(COR1_CONCAT),
    .XFER_TRIGGER(XFER_TRIGGER), .AUX_ADDR_HIGH(AUX_ADDR_HIGH), .PROM_ADVANCE(PROM_ADVANCE), .CFG_CLK(CFG_CLK));

`default_nettype wire
